// ==== logic/fsg_pkg.sv ====
// Package for the suspend/resume command gate.
// Assumes a 100 MHz core clock and an upstream opcode decoder.
package fsg_pkg;

  // Opcodes handled by the gate itself
  localparam logic [7:0] FSG_OP_SUSPEND = 8'hB0;
  localparam logic [7:0] FSG_OP_RESUME  = 8'hD0;

  // Timing: resume latency in ns, count in clock cycles
  localparam int FSG_CLK_PERIOD_NS     = 10;
  localparam int FSG_RESUME_LATENCY_NS = 20000;
  localparam int FSG_RESUME_CYC        = FSG_RESUME_LATENCY_NS / FSG_CLK_PERIOD_NS;
  localparam int FSG_CNT_W             = 12;

  // Reset values
  localparam logic FSG_FLAG_RST = 1'b0;

  // Command classes from the opcode decoder
  typedef enum logic [3:0] {
    FSG_C_RD_ARRAY  = 4'h0,
    FSG_C_RD_BUF    = 4'h1,
    FSG_C_WR_BUFA   = 4'h2,
    FSG_C_WR_BUFB   = 4'h3,
    FSG_C_PGM_ERASE = 4'h4,
    FSG_C_PGM_NOERA = 4'h5,
    FSG_C_ERASE     = 4'h6,
    FSG_C_PROT_WR   = 4'h7,
    FSG_C_PROT_RD   = 4'h8,
    FSG_C_XFER_A    = 4'h9,
    FSG_C_XFER_B    = 4'hA,
    FSG_C_CMP       = 4'hB,
    FSG_C_PWRDN     = 4'hC,
    FSG_C_INFO_RD   = 4'hD,
    FSG_C_RESET     = 4'hE,
    FSG_C_OTHER     = 4'hF
  } fsg_class_t;

  // Kind of frame in progress
  typedef enum logic [1:0] {
    FSG_K_NONE = 2'b00,
    FSG_K_CMD  = 2'b01,
    FSG_K_SUSP = 2'b11,
    FSG_K_RES  = 2'b10
  } fsg_kind_t;

  // Resume sequencer
  typedef enum logic [1:0] {
    FSG_RS_IDLE = 2'b00,
    FSG_RS_WAIT = 2'b01
  } fsg_rstate_t;

endpackage

// ==== logic/fsg_gate.sv ====
// Suspend/resume command gate of the serial flash.
// Assumes opcode strobes on clk; chip select and reset pin are asynchronous.
`timescale 1ns/100ps

//Contract
// R1: Array and buffer reads always allowed while suspended
// R2: Suspended buffer rejects writes; other buffer allowed
// R3: Programs with erase and rewrite always rejected
// R4: No-erase programs only during erase suspend
// R5: All erase commands rejected while suspended
// R6: Protection, lock and security writes rejected
// R7: Protection, lock and security reads allowed
// R8: Transfer into suspended buffer rejected
// R9: Compare commands always allowed
// R10: Power-down entry and exit rejected
// R11: Config, status and identity reads allowed
// R12: Pin or command reset always accepted
// R13: Resume opcode alone, acted on at select release; gate ignores trailing bytes instead of rejecting the frame
// R14: Resume clears flag, shows busy for latency
// R15: Resumed operation continues, not restarted
// R16: Program resumes before erase; erase needs second
// R17: Suspend ignored while resume in progress
// R18: Host waits latency or polls before resuspend
// R19: Suspend at select release sets flag, ready
// R20: Program to erase-suspended sector aborted; gate rejects it instead
// R21: Rejected command changes nothing
module fsg_gate
  import fsg_pkg::*;
#(
  parameter int RESUME_CYC = FSG_RESUME_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       csN,
  input  wire logic       hwResetN,
  input  wire logic       opcValid,
  input  wire logic [7:0] opcByte,
  input  wire fsg_class_t opcClass,
  input  wire logic       sectorHit,
  input  wire logic       opActive,
  input  wire logic       opIsErase,
  input  wire logic       opBufB,
  output logic            cmdAllow,
  output logic            cmdGo,
  output logic            cmdDrop,
  output logic            suspendReq,
  output logic            resumeProgReq,
  output logic            resumeEraseReq,
  output logic            abortAll,
  output logic            bufAProgSuspended,
  output logic            bufBProgSuspended,
  output logic            eraseSuspendedFlag,
  output logic            busy,
  output logic            readUndefined
);

  localparam logic [FSG_CNT_W-1:0] RES_LOAD = FSG_CNT_W'(RESUME_CYC - 1);

  // Pin synchronisers
  logic csMeta_q, csSync_q, csLast_q;
  logic rstMeta_q, rstSync_q;
  logic csMeta_d, csSync_d, csLast_d;
  logic rstMeta_d, rstSync_d;

  always_comb begin
    csMeta_d  = csN;
    csSync_d  = csMeta_q;
    csLast_d  = csSync_q;
    rstMeta_d = hwResetN;
    rstSync_d = rstMeta_q;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      csMeta_q  <= 1'b1;
      csSync_q  <= 1'b1;
      csLast_q  <= 1'b1;
      rstMeta_q <= 1'b1;
      rstSync_q <= 1'b1;
    end else begin
      csMeta_q  <= csMeta_d;
      csSync_q  <= csSync_d;
      csLast_q  <= csLast_d;
      rstMeta_q <= rstMeta_d;
      rstSync_q <= rstSync_d;
    end
  end

  // Allowed-in-suspend table
  function automatic logic fsgAllowed(
    input fsg_class_t c,
    input logic       a,
    input logic       b,
    input logic       e,
    input logic       hit
  );
    logic ok;
    ok = 1'b0;
    if (!(a || b || e)) begin
      ok = 1'b1;
    end else begin
      case (c)
        FSG_C_RD_ARRAY:  ok = 1'b1;             // R1
        FSG_C_RD_BUF:    ok = 1'b1;             // R1
        FSG_C_WR_BUFA:   ok = !a;               // R2
        FSG_C_WR_BUFB:   ok = !b;               // R2
        FSG_C_PGM_ERASE: ok = 1'b0;             // R3
        FSG_C_PGM_NOERA: ok = !a && !b && !hit; // R4
        FSG_C_ERASE:     ok = 1'b0;             // R5
        FSG_C_PROT_WR:   ok = 1'b0;             // R6
        FSG_C_PROT_RD:   ok = 1'b1;             // R7
        FSG_C_XFER_A:    ok = !a;               // R8
        FSG_C_XFER_B:    ok = !b;               // R8
        FSG_C_CMP:       ok = 1'b1;             // R9
        FSG_C_PWRDN:     ok = 1'b0;             // R10
        FSG_C_INFO_RD:   ok = 1'b1;             // R11
        FSG_C_RESET:     ok = 1'b1;             // R12
        default:         ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // Frame and control state
  fsg_kind_t             kind_q, kind_d;
  fsg_class_t            class_q, class_d;
  fsg_rstate_t           rs_q, rs_d;
  logic [FSG_CNT_W-1:0]  cnt_q, cnt_d;
  logic                  a_q, a_d, b_q, b_d, e_q, e_d;
  logic                  allow_q, allow_d, go_q, go_d, drop_q, drop_d;
  logic                  susp_q, susp_d, resP_q, resP_d, resE_q, resE_d;
  logic                  abort_q, abort_d, busy_q, busy_d, undef_q, undef_d;

  logic csRise, hwRst, anySusp, cmdOk, cmdReset;
  logic doSusp, doResP, doResE;

  assign csRise   = csSync_q && !csLast_q;
  assign hwRst    = !rstSync_q;
  assign anySusp  = a_q || b_q || e_q;
  assign cmdOk    = fsgAllowed(class_q, a_q, b_q, e_q, sectorHit);
  assign cmdReset = csRise && kind_q == FSG_K_CMD && class_q == FSG_C_RESET;
  assign doSusp   = csRise && kind_q == FSG_K_SUSP && rs_q == FSG_RS_IDLE && opActive && !hwRst;
  assign doResP   = csRise && kind_q == FSG_K_RES && rs_q == FSG_RS_IDLE && !opActive && (a_q || b_q) && !hwRst;
  assign doResE   = csRise && kind_q == FSG_K_RES && rs_q == FSG_RS_IDLE && !opActive && !a_q && !b_q && e_q
                    && !hwRst;

  always_comb begin
    kind_d  = kind_q;
    class_d = class_q;
    rs_d    = rs_q;
    cnt_d   = cnt_q;
    a_d     = a_q;
    b_d     = b_q;
    e_d     = e_q;
    allow_d = allow_q;
    go_d    = 1'b0;
    drop_d  = 1'b0;
    susp_d  = 1'b0;
    resP_d  = 1'b0;
    resE_d  = 1'b0;
    abort_d = 1'b0;
    undef_d = undef_q;
    // First byte of a frame decides its kind; later bytes ignored
    if (opcValid && kind_q == FSG_K_NONE) begin  // R13
      undef_d = 1'b0;
      if (opcByte == FSG_OP_SUSPEND) begin
        kind_d  = FSG_K_SUSP;
        allow_d = rs_q == FSG_RS_IDLE && opActive;
      end else if (opcByte == FSG_OP_RESUME) begin
        kind_d  = FSG_K_RES;
        allow_d = rs_q == FSG_RS_IDLE && anySusp && !opActive;
      end else begin
        kind_d  = FSG_K_CMD;
        class_d = opcClass;
        allow_d = fsgAllowed(opcClass, a_q, b_q, e_q, sectorHit);
      end
    end
    // Resume latency countdown
    case (rs_q)
      FSG_RS_WAIT: begin
        cnt_d = cnt_q - FSG_CNT_W'(1);
        if (cnt_q == '0) begin
          rs_d = FSG_RS_IDLE;
        end
      end
      default: begin
        cnt_d = '0;
      end
    endcase
    // Select release executes the frame
    if (csRise) begin
      kind_d  = FSG_K_NONE;
      allow_d = 1'b0;
      case (kind_q)
        FSG_K_CMD: begin
          go_d    = cmdOk;
          drop_d  = !cmdOk;  // R21
          undef_d = cmdOk && class_q == FSG_C_RD_ARRAY && sectorHit && anySusp;  // R20
        end
        FSG_K_SUSP: begin
          drop_d = !doSusp;  // R17
          if (doSusp) begin
            susp_d = 1'b1;  // R19
            if (opIsErase) begin
              e_d = 1'b1;
            end else if (opBufB) begin
              b_d = 1'b1;
            end else begin
              a_d = 1'b1;
            end
          end
        end
        FSG_K_RES: begin
          drop_d = !(doResP || doResE);
          if (doResP) begin
            resP_d = 1'b1;  // R16
            if (a_q) begin
              a_d = 1'b0;  // R14
            end else begin
              b_d = 1'b0;
            end
          end else if (doResE) begin
            resE_d = 1'b1;
            e_d    = 1'b0;  // R14
          end
          if (doResP || doResE) begin
            rs_d  = FSG_RS_WAIT;  // R15
            cnt_d = RES_LOAD;
          end
        end
        default: begin
          drop_d = 1'b0;
        end
      endcase
    end
    // Reset from pin or command wins over the flags, the resume sequencer and the request pulses
    if (hwRst || cmdReset) begin  // R12
      a_d     = FSG_FLAG_RST;
      b_d     = FSG_FLAG_RST;
      e_d     = FSG_FLAG_RST;
      rs_d    = FSG_RS_IDLE;
      cnt_d   = '0;
      susp_d  = 1'b0;
      resP_d  = 1'b0;
      resE_d  = 1'b0;
      abort_d = 1'b1;
    end
    // Engine drops opActive one cycle after the suspend pulse; keep ready meanwhile
    busy_d = (opActive && !susp_d && !susp_q) || rs_d == FSG_RS_WAIT;  // R14 R19
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      kind_q  <= FSG_K_NONE;
      class_q <= FSG_C_OTHER;
      rs_q    <= FSG_RS_IDLE;
      cnt_q   <= '0;
      a_q     <= FSG_FLAG_RST;
      b_q     <= FSG_FLAG_RST;
      e_q     <= FSG_FLAG_RST;
      allow_q <= 1'b0;
      go_q    <= 1'b0;
      drop_q  <= 1'b0;
      susp_q  <= 1'b0;
      resP_q  <= 1'b0;
      resE_q  <= 1'b0;
      abort_q <= 1'b0;
      busy_q  <= 1'b0;
      undef_q <= 1'b0;
    end else begin
      kind_q  <= kind_d;
      class_q <= class_d;
      rs_q    <= rs_d;
      cnt_q   <= cnt_d;
      a_q     <= a_d;
      b_q     <= b_d;
      e_q     <= e_d;
      allow_q <= allow_d;
      go_q    <= go_d;
      drop_q  <= drop_d;
      susp_q  <= susp_d;
      resP_q  <= resP_d;
      resE_q  <= resE_d;
      abort_q <= abort_d;
      busy_q  <= busy_d;
      undef_q <= undef_d;
    end
  end

  assign cmdAllow           = allow_q;
  assign cmdGo              = go_q;
  assign cmdDrop            = drop_q;
  assign suspendReq         = susp_q;
  assign resumeProgReq      = resP_q;
  assign resumeEraseReq     = resE_q;
  assign abortAll           = abort_q;
  assign bufAProgSuspended  = a_q;
  assign bufBProgSuspended  = b_q;
  assign eraseSuspendedFlag = e_q;
  assign busy               = busy_q;
  assign readUndefined      = undef_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic cmdEdge;
  assign cmdEdge = csRise && kind_q == FSG_K_CMD;

  read_ok_a: assert property (cmdEdge && class_q == FSG_C_RD_ARRAY |=> cmdGo && !cmdDrop) // R1
    else $error("array read refused");
  bufa_wr_a: assert property (cmdEdge && class_q == FSG_C_WR_BUFA && a_q |=> cmdDrop && !cmdGo) // R2
    else $error("write to suspended buffer taken");
  pgm_erase_a: assert property (cmdEdge && class_q == FSG_C_PGM_ERASE && anySusp |=> cmdDrop) // R3
    else $error("program with erase taken in suspend");
  noera_a: assert property (cmdEdge && class_q == FSG_C_PGM_NOERA && (a_q || b_q) |=> cmdDrop) // R4
    else $error("no-erase program taken in program suspend");
  erase_drop_a: assert property (cmdEdge && class_q == FSG_C_ERASE && anySusp |=> cmdDrop) // R5
    else $error("erase taken in suspend");
  pwrdn_drop_a: assert property (cmdEdge && class_q == FSG_C_PWRDN && anySusp |=> cmdDrop) // R10
    else $error("power-down taken in suspend");
  reset_clr_a: assert property (hwRst |=> !bufAProgSuspended && !bufBProgSuspended && !eraseSuspendedFlag) // R12
    else $error("suspend flags kept through reset");
  res_clear_a: assert property (doResP && a_q |=> resumeProgReq && busy && !bufAProgSuspended) // R14
    else $error("resume did not clear flag");
  res_order_a: assert property (doResP && e_q |=> eraseSuspendedFlag && !resumeEraseReq) // R16
    else $error("erase resumed before program");
  res_wait_a: assert property (doResP || doResE |=> (rs_q == FSG_RS_WAIT && busy)[*8]) // R14
    else $error("resume latency cut short");
  susp_ign_a: assert property (csRise && kind_q == FSG_K_SUSP && rs_q == FSG_RS_WAIT |=> !suspendReq) // R17
    else $error("suspend taken while resuming");
  susp_set_a: assert property (doSusp && opIsErase |=> suspendReq && eraseSuspendedFlag) // R19
    else $error("erase suspend flag not set");
  drop_keep_a: assert property (cmdDrop && !$past(hwRst) |-> a_q == $past(a_q) && e_q == $past(e_q)) // R21
    else $error("rejected command changed flags");

  susp_c: cover property (doSusp);
  both_c: cover property (e_q && (a_q || b_q));
  res_e_c: cover property (doResE);
  drop_c: cover property (cmdEdge && !cmdOk);

endmodule

// ==== sim/fsg_engine_model.sv ====
// Behavioural program/erase engine behind the suspend/resume gate.
// Assumes start requests come from the bench, one cycle each.
`timescale 1ns/100ps
module fsg_engine_model #(
  parameter int PROG_LEN  = 40,
  parameter int ERASE_LEN = 60
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic startOp,
  input  wire logic startErase,
  input  wire logic startBufB,
  input  wire logic suspendReq,
  input  wire logic resumeProgReq,
  input  wire logic resumeEraseReq,
  input  wire logic abortAll,
  output logic      opActive,
  output logic      opIsErase,
  output logic      opBufB
);
  logic [7:0] remQ;
  logic [7:0] progRemQ;
  logic [7:0] eraRemQ;

  always_ff @(posedge clk) begin
    if (!resetn || abortAll) begin
      opActive  <= 1'h0;
      opIsErase <= 1'h0;
      opBufB    <= 1'h0;
      remQ      <= 8'h00;
      progRemQ  <= 8'h00;
      eraRemQ   <= 8'h00;
    end else if (startOp) begin
      opActive  <= 1'h1;
      opIsErase <= startErase;
      opBufB    <= startBufB;
      remQ      <= startErase ? 8'(ERASE_LEN) : 8'(PROG_LEN);
    end else if (suspendReq) begin
      opActive <= 1'h0;
      if (opIsErase) eraRemQ <= remQ;
      else progRemQ <= remQ;
    end else if (resumeProgReq) begin
      opActive  <= 1'h1;
      opIsErase <= 1'h0;
      remQ      <= progRemQ;
    end else if (resumeEraseReq) begin
      opActive  <= 1'h1;
      opIsErase <= 1'h1;
      remQ      <= eraRemQ;
    end else if (opActive) begin
      remQ <= remQ - 8'h01;
      if (remQ == 8'h01) opActive <= 1'h0;
    end
  end
endmodule

// ==== sim/fsg_gate_tb_top.sv ====
// Self-checking bench for the suspend/resume gate.
// Acts as the host sending frames; the engine model drives the op status.
`timescale 1ns/100ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin fails++; $display("Error %0t got %h exp %h", $time, a, e); end end
module fsg_gate_tb_top;
  import fsg_pkg::*;
  logic       clk, resetn, csN, hwResetN, opcValid, sectorHit;
  logic [7:0] opcByte;
  fsg_class_t opcClass;
  logic       startOp, startErase, startBufB, opActive, opIsErase, opBufB;
  logic       cmdAllow, cmdGo, cmdDrop, suspendReq, resumeProgReq, resumeEraseReq, abortAll;
  logic       bufAProgSuspended, bufBProgSuspended, eraseSuspendedFlag, busy, readUndefined;
  logic       go, drop, sp, rp, re, al;
  logic [2:0] flags;
  int         fails, nCompared;

  assign flags = {eraseSuspendedFlag, bufBProgSuspended, bufAProgSuspended};

  fsg_gate #(.RESUME_CYC(16)) i_fsg_gate (
    .clk(clk), .resetn(resetn), .csN(csN), .hwResetN(hwResetN), .opcValid(opcValid), .opcByte(opcByte),
    .opcClass(opcClass), .sectorHit(sectorHit), .opActive(opActive), .opIsErase(opIsErase), .opBufB(opBufB),
    .cmdAllow(cmdAllow), .cmdGo(cmdGo), .cmdDrop(cmdDrop), .suspendReq(suspendReq),
    .resumeProgReq(resumeProgReq), .resumeEraseReq(resumeEraseReq), .abortAll(abortAll),
    .bufAProgSuspended(bufAProgSuspended), .bufBProgSuspended(bufBProgSuspended),
    .eraseSuspendedFlag(eraseSuspendedFlag), .busy(busy), .readUndefined(readUndefined));

  fsg_engine_model i_fsg_engine_model (
    .clk(clk), .resetn(resetn), .startOp(startOp), .startErase(startErase), .startBufB(startBufB),
    .suspendReq(suspendReq), .resumeProgReq(resumeProgReq), .resumeEraseReq(resumeEraseReq),
    .abortAll(abortAll), .opActive(opActive), .opIsErase(opIsErase), .opBufB(opBufB));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic bit allowed(input fsg_class_t c, input int st);
    case (c)
      FSG_C_WR_BUFA, FSG_C_XFER_A: return st != 0;
      FSG_C_WR_BUFB, FSG_C_XFER_B: return st != 1;
      FSG_C_PGM_NOERA: return st == 2;
      FSG_C_RD_ARRAY, FSG_C_RD_BUF, FSG_C_PROT_RD, FSG_C_CMP, FSG_C_INFO_RD: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // One select period: opcode, optional trailing byte, then release
  task automatic frame(input logic [7:0] b, input fsg_class_t c, input bit extra);
    int i;
    @(posedge clk) csN <= 1'h0;
    @(posedge clk) begin opcValid <= 1'h1; opcByte <= b; opcClass <= c; end
    @(posedge clk) opcValid <= 1'h0;
    @(negedge clk) al = cmdAllow;
    if (extra) begin
      @(posedge clk) begin opcValid <= 1'h1; opcByte <= FSG_OP_SUSPEND; end
      @(posedge clk) opcValid <= 1'h0;
    end
    @(posedge clk) csN <= 1'h1;
    {go, drop, sp, rp, re} = 5'h00;
    for (i = 0; i < 12; i++) begin
      @(negedge clk);
      {go, drop, sp, rp, re} = {cmdGo, cmdDrop, suspendReq, resumeProgReq, resumeEraseReq};
      if (go | drop | sp | rp | re) break;
    end
    if (i == 12) begin fails++; report_and_stop(); end
  endtask

  task automatic suspend_run(input bit er, input bit bb, input logic [2:0] expF);
    @(posedge clk) begin startOp <= 1'h1; startErase <= er; startBufB <= bb; end
    @(posedge clk) startOp <= 1'h0;
    repeat (5) @(posedge clk);
    frame(FSG_OP_SUSPEND, FSG_C_OTHER, 1'b0);
    `CHK({sp, al, flags, busy}, {1'h1, 1'h1, expF, 1'h0})
    @(negedge clk);
    `CHK(busy, 1'h0)
  endtask

  task automatic resume_run(input bit isProg, input logic [2:0] expF);
    frame(FSG_OP_RESUME, FSG_C_OTHER, 1'b1);
    `CHK({rp, re, sp}, {isProg, !isProg, 1'h0})
    `CHK({flags, busy}, {expF, 1'h1})
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (!busy && !opActive) break;
    end
    if (i == 300) begin fails++; report_and_stop(); end
  endtask

  task automatic class_loop(input int st, input logic [2:0] expF);
    for (int k = 0; k < 16; k++) begin
      if (k != 14) begin
        frame(8'h01, fsg_class_t'(k), 1'b0);
        `CHK(go, allowed(fsg_class_t'(k), st))
        `CHK(al, allowed(fsg_class_t'(k), st))
        `CHK({flags, drop}, {expF, !allowed(fsg_class_t'(k), st)})
      end
    end
    $display("test state %0d done", st);
  endtask

  initial begin
    {resetn, csN, hwResetN, opcValid, sectorHit, startOp, startErase, startBufB} = 8'h60;
    opcByte = 8'h00;
    opcClass = FSG_C_OTHER;
    fails = 0;
    nCompared = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    frame(8'h01, FSG_C_ERASE, 1'b0);
    `CHK(go, 1'h1)
    frame(FSG_OP_RESUME, FSG_C_OTHER, 1'b0);
    `CHK({drop, rp, re}, 3'h4)
    suspend_run(1'b0, 1'b0, 3'h1);
    class_loop(0, 3'h1);
    resume_run(1'b1, 3'h0);
    frame(FSG_OP_SUSPEND, FSG_C_OTHER, 1'b0);
    `CHK({sp, drop, flags}, 5'h08)
    wait_idle();
    suspend_run(1'b0, 1'b1, 3'h2);
    class_loop(1, 3'h2);
    resume_run(1'b1, 3'h0);
    wait_idle();
    suspend_run(1'b1, 1'b0, 3'h4);
    class_loop(2, 3'h4);
    @(posedge clk) sectorHit <= 1'h1;
    frame(8'h01, FSG_C_RD_ARRAY, 1'b0);
    `CHK({go, readUndefined}, 2'h3)
    frame(8'h01, FSG_C_PGM_NOERA, 1'b0);
    `CHK({go, drop}, 2'h1)
    @(posedge clk) sectorHit <= 1'h0;
    suspend_run(1'b0, 1'b0, 3'h5);
    resume_run(1'b1, 3'h4);
    wait_idle();
    resume_run(1'b0, 3'h0);
    wait_idle();
    frame(FSG_OP_RESUME, FSG_C_OTHER, 1'b0);
    `CHK({drop, re}, 2'h2)
    $display("test nested resume done");
    suspend_run(1'b1, 1'b0, 3'h4);
    frame(8'h01, FSG_C_RESET, 1'b0);
    `CHK({go, flags}, 4'h8)
    suspend_run(1'b0, 1'b1, 3'h2);
    @(posedge clk) hwResetN <= 1'h0;
    repeat (6) @(negedge clk);
    `CHK({abortAll, flags}, 4'h8)
    @(posedge clk) hwResetN <= 1'h1;
    wait_idle();
    $display("test reset done");
    report_and_stop();
  end
endmodule
